// [logic/aif_bus_if.sv]
`default_nettype none
interface aif_bus_if;
    logic        rd_req;
    logic [7:0]  rd_addr;
    logic        rd_ack;
    logic [15:0] rd_data;

    modport dev  (input rd_req, input rd_addr, output rd_ack, output rd_data);
    modport host (output rd_req, output rd_addr, input rd_ack, input rd_data);
endinterface
`default_nettype wire

// [logic/aif_device.sv]
`default_nettype none
module aif_device
    import aif_pkg::*;
#(
    parameter int CHANNELS = aif_pkg::AIF_CHANNELS
) (
    input  wire logic                                clk_in,
    input  wire logic                                reset_n_in,
    input  wire logic                                ce_in,
    aif_bus_if.dev                                   bus,
    input  wire logic                                conv_done_in,
    input  wire logic [aif_pkg::AIF_CH_W-1:0]        conv_chan_in,
    input  wire logic signed [aif_pkg::AIF_RAW_W-1:0] conv_value_in,
    input  wire logic                                conv_wire_break_in,
    input  wire logic                                scan_start_in,
    input  wire logic [aif_pkg::AIF_CH_W-1:0]        scan_chan_in,
    input  wire logic [1:0]                          fmt_sel_in,
    input  wire logic [2:0]                          base_sel_in,
    input  wire logic                                simple_variant_in,
    input  wire logic                                bipolar_range_in,
    input  wire logic                                live_zero_in,
    input  wire logic                                shunt_adapter_in,
    input  wire logic                                xdcr_break_in,
    input  wire logic                                supply_break_in
);
    import aif_pkg::*;

    // count of synchronised switch and fault pins
    localparam int PIN_W = 11;

    // synchroniser stages, result memory, read port
    logic [PIN_W-1:0]      pin_meta_ff;
    logic [PIN_W-1:0]      pin_ff;
    logic [AIF_WORD_W-1:0] mem_ff [CHANNELS];
    logic                  rd_ack_ff;
    logic [AIF_WORD_W-1:0] rd_data_ff;

    // switch and fault pins in one vector
    wire logic [PIN_W-1:0] pin_raw = {
        supply_break_in,
        xdcr_break_in,
        shunt_adapter_in,
        live_zero_in,
        bipolar_range_in,
        simple_variant_in,
        base_sel_in,
        fmt_sel_in
    };

    // switches and fault levels come from outside: two-flop synchroniser
    // only the second stage is read; a switch change may look mixed for one cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_meta_ff <= '0;
            pin_ff      <= '0;
        end else if (ce_in) begin
            pin_meta_ff <= pin_raw;
            pin_ff      <= pin_meta_ff;
        end
    end

    // synchronised settings
    // a pin change takes effect two edges later
    wire logic [1:0] fmt      = pin_ff[1:0];
    wire logic [2:0] base_sel = pin_ff[4:2];
    wire logic       simple   = pin_ff[5];
    wire logic       bipolar  = pin_ff[6];
    wire logic       lz       = pin_ff[7];
    wire logic       shunt    = pin_ff[8];
    wire logic       xdcr_brk = pin_ff[9];
    wire logic       sup_brk  = pin_ff[10];

    // format decode
    wire logic       is_bin   = (fmt == AIF_FMT_BIN);
    wire logic       is_smag  = (fmt == AIF_FMT_SMAG);

    // level in units, live-zero range shifted up by its offset
    // sign-extend first so the offset cannot wrap
    wire logic signed [15:0] raw16 = {{2{conv_value_in[AIF_RAW_W-1]}}, conv_value_in};
    wire logic signed [15:0] lvl   = lz ? raw16 + AIF_LZ_OFS : raw16;

    // span of the selected encoding; simple variant has no overrange
    // format code 3 is not decoded and acts as two's complement
    wire logic signed [15:0] hi_lim =
        !bipolar        ? ((lz && simple) ? AIF_LZ_MAX : AIF_UNI_MAX) :
        (is_bin || simple) ? AIF_BI_MAX : AIF_OVR_MAX;

    // sign-magnitude on the simple variant stops at -2047
    wire logic signed [15:0] lo_lim =
        !bipolar        ? AIF_UNI_MIN :
        is_bin          ? AIF_BI_MIN :
        simple          ? (is_smag ? AIF_SM_MIN : AIF_BI_MIN) :
        AIF_OVR_MIN;

    // clamp and flag out-of-range input
    // the clamped value stays in span; the flag tells the reader
    wire logic               too_hi = (lvl > hi_lim);
    wire logic               too_lo = (lvl < lo_lim);
    wire logic signed [15:0] sat    = too_hi ? hi_lim : too_lo ? lo_lim : lvl;
    wire logic               neg    = sat[15];
    wire logic signed [15:0] mag    = neg ? -sat : sat;
    // binary bipolar moves the span up by half
    wire logic signed [15:0] boff   = sat + AIF_BIN_OFS;

    // value field, word bits 15..3
    wire logic [12:0] enc_uni  = {1'b0, sat[11:0]};
    wire logic [12:0] enc_bin  = {1'b0, boff[11:0]};
    wire logic [12:0] enc_smag = {neg, mag[11:0]};
    // simple variant: sign in bit 15, bit 14 held at zero
    wire logic [12:0] enc_tc   = simple ? {sat[12], 1'b0, sat[10:0]}
                                        : sat[12:0];

    // unipolar ranges use one layout whatever the format
    wire logic [12:0] enc      = !bipolar ? enc_uni :
                                 is_bin   ? enc_bin :
                                 is_smag  ? enc_smag : enc_tc;

    // status bits of a fresh word; stale flags are not carried over
    // break levels also feed each fresh word, so a conversion cannot hide them
    wire logic new_ov = too_hi | too_lo |
                        xdcr_brk | sup_brk;
    wire logic new_f  = !shunt & (conv_wire_break_in | sup_brk);
    wire logic [AIF_WORD_W-1:0] word_new = {enc, 1'b0, new_f, new_ov};

    // one result word per channel
    // a conversion write wins over the all-channel sets in one cycle
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_ent
            // conversion or single scan aimed at this entry
            wire logic wr_hit = conv_done_in && (conv_chan_in == AIF_CH_W'(gi));
            wire logic a_hit  = scan_start_in && (scan_chan_in == AIF_CH_W'(gi)) && !simple;

            // store conversion, or raise this entry's activity flag and the flags that apply to every channel
            // an entry's own wire-break fault only comes with its conversion
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    mem_ff[gi] <= AIF_WORD_RST;
                end else if (ce_in) begin
                    if (wr_hit) begin
                        mem_ff[gi] <= word_new;
                    end else begin
                        if (a_hit) begin
                            mem_ff[gi][AIF_A_BIT] <= 1'b1;
                        end
                        if (xdcr_brk || sup_brk) begin
                            mem_ff[gi][AIF_OV_BIT] <= 1'b1;
                        end
                        if (sup_brk && !shunt) begin
                            mem_ff[gi][AIF_F_BIT] <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // address decode within the 16-byte window
    // both bytes of a word select it; odd and even read alike
    // a request past the last channel gets no answer
    wire logic [AIF_ADDR_W-1:0] base   = aif_base_addr(base_sel);
    wire logic [AIF_ADDR_W-1:0] off    = bus.rd_addr - base;
    wire logic [AIF_CH_W-1:0]   idx    = off[AIF_CH_W:1];
    wire logic                  in_win = (bus.rd_addr >= base) && (off < AIF_WIN_BYTES);
    wire logic                  rd_hit = bus.rd_req &&
                                         in_win &&
                                         (32'(idx) < CHANNELS);

    // answer one cycle after a matching request
    // rd_ack pulses once per request; rd_data holds until the next hit
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_ack_ff  <= 1'b0;
            rd_data_ff <= AIF_WORD_RST;
        end else if (ce_in) begin
            rd_ack_ff <= rd_hit;
            if (rd_hit) begin
                rd_data_ff <= mem_ff[idx];
            end
        end
    end

    // read port driven straight from flops
    assign bus.rd_ack  = rd_ack_ff;
    assign bus.rd_data = rd_data_ff;
endmodule // aif_device
`default_nettype wire

// [logic/aif_host.sv]
// Local design decisions: the AXI4-Lite register port and the address map.
`default_nettype none
module aif_host
    import aif_pkg::*;
#(
    parameter int TMO_CYC = aif_pkg::AIF_RESP_TMO_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        ce_in,
    aif_bus_if.host          bus,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in
);
    import aif_pkg::*;

    logic                  awready_ff;
    logic                  bvalid_ff;
    logic [1:0]            bresp_ff;
    logic                  arready_ff;
    logic                  rvalid_ff;
    logic [1:0]            rresp_ff;
    logic [31:0]           rdata_ff;
    logic [AIF_CH_W-1:0]   chan_ff;
    logic [7:0]            cfg_ff;
    logic [15:0]           limit_ff;
    logic [AIF_WORD_W-1:0] raw_ff;
    logic                  done_ff;
    logic                  tmo_ff;
    logic                  req_ff;
    logic [7:0]            addr_ff;
    logic [15:0]           cnt_ff;
    aif_hst_e              state_ff;

    // write channel: address and data taken together
    wire logic aw_go   = s_axi_awvalid_in && s_axi_wvalid_in && !awready_ff && !bvalid_ff;
    wire logic wr_fire = awready_ff && s_axi_awvalid_in && s_axi_wvalid_in;
    wire logic w_cmd   = (s_axi_awaddr_in == AIF_REG_CMD);
    wire logic w_cfg   = (s_axi_awaddr_in == AIF_REG_CFG);
    wire logic w_lim   = (s_axi_awaddr_in == AIF_REG_LIMIT);
    wire logic w_ok    = w_cmd || w_cfg || w_lim || (s_axi_awaddr_in == AIF_REG_STATUS) ||
                         (s_axi_awaddr_in == AIF_REG_RAW) || (s_axi_awaddr_in == AIF_REG_VALUE);
    wire logic idle    = (state_ff == AIF_H_IDLE);
    wire logic start   = wr_fire && w_cmd && s_axi_wstrb_in[0] && idle;

    // config fields
    wire logic [2:0] c_base = cfg_ff[2:0];
    wire logic [1:0] c_fmt  = cfg_ff[4:3];
    wire logic       c_bip  = cfg_ff[5];
    wire logic       c_lz   = cfg_ff[6];
    wire logic       c_simp = cfg_ff[7];

    // decode the stored word, status bits masked off
    wire logic [12:0] e     = raw_ff[AIF_WORD_W-1:AIF_VAL_LSB];
    wire logic [15:0] v_uni = {4'h0, e[11:0]};
    wire logic [15:0] v_tc  = c_simp ? {{5{e[12]}}, e[10:0]} : {{3{e[12]}}, e[12:0]};
    wire logic [15:0] v_sm  = e[12] ? 16'h0000 - v_uni : v_uni;
    wire logic [15:0] v_bin = v_uni - AIF_BIN_OFS;
    wire logic [15:0] v_sel = !c_bip ? v_uni : (c_fmt == AIF_FMT_BIN) ? v_bin :
                              (c_fmt == AIF_FMT_SMAG) ? v_sm : v_tc;
    wire logic [15:0] value = c_lz ? v_sel - AIF_LZ_OFS : v_sel;
    wire logic below = $signed(value) < $signed(limit_ff);

    // read channel
    wire logic ar_go   = s_axi_arvalid_in && !arready_ff && !rvalid_ff;
    wire logic rd_fire = arready_ff && s_axi_arvalid_in;
    wire logic [31:0] status = {25'h0, below, raw_ff[AIF_A_BIT], raw_ff[AIF_F_BIT],
                                raw_ff[AIF_OV_BIT], tmo_ff, done_ff, !idle};
    wire logic r_ok = (s_axi_araddr_in == AIF_REG_CMD) || (s_axi_araddr_in == AIF_REG_CFG) ||
                      (s_axi_araddr_in == AIF_REG_LIMIT) || (s_axi_araddr_in == AIF_REG_STATUS) ||
                      (s_axi_araddr_in == AIF_REG_RAW) || (s_axi_araddr_in == AIF_REG_VALUE);
    wire logic [31:0] rd_mux =
        (s_axi_araddr_in == AIF_REG_CMD)    ? {29'h0, chan_ff} :
        (s_axi_araddr_in == AIF_REG_CFG)    ? {24'h0, cfg_ff} :
        (s_axi_araddr_in == AIF_REG_LIMIT)  ? {16'h0, limit_ff} :
        (s_axi_araddr_in == AIF_REG_STATUS) ? status :
        (s_axi_araddr_in == AIF_REG_RAW)    ? {16'h0, raw_ff} :
        (s_axi_araddr_in == AIF_REG_VALUE)  ? {{16{value[15]}}, value} : 32'h0;

    // bus handshakes
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            awready_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= AIF_RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= AIF_RESP_OKAY;
            rdata_ff   <= 32'h0;
        end else if (ce_in) begin
            awready_ff <= aw_go;
            arready_ff <= ar_go;
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= w_ok ? AIF_RESP_OKAY : AIF_RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                bvalid_ff <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= r_ok ? AIF_RESP_OKAY : AIF_RESP_SLVERR;
                rdata_ff  <= rd_mux;
            end else if (s_axi_rready_in) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // software registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            chan_ff  <= '0;
            cfg_ff   <= AIF_CFG_RST;
            limit_ff <= AIF_LIMIT_RST;
        end else if (ce_in && wr_fire) begin
            if (start) chan_ff <= s_axi_wdata_in[AIF_CH_W-1:0];
            if (w_cfg && s_axi_wstrb_in[0]) cfg_ff <= s_axi_wdata_in[7:0];
            if (w_lim && s_axi_wstrb_in[0]) limit_ff[7:0] <= s_axi_wdata_in[7:0];
            if (w_lim && s_axi_wstrb_in[1]) limit_ff[15:8] <= s_axi_wdata_in[15:8];
        end
    end

    // read sequencer: one request, then wait for the answer or timeout
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff <= AIF_H_IDLE;
            req_ff   <= 1'b0;
            addr_ff  <= 8'h00;
            cnt_ff   <= 16'h0000;
            raw_ff   <= AIF_WORD_RST;
            done_ff  <= 1'b0;
            tmo_ff   <= 1'b0;
        end else if (ce_in) begin
            unique case (state_ff)
                AIF_H_IDLE: begin
                    if (start) begin
                        req_ff   <= 1'b1;
                        addr_ff  <= aif_base_addr(c_base) +
                                    {4'h0, s_axi_wdata_in[AIF_CH_W-1:0], 1'b0};
                        cnt_ff   <= 16'h0000;
                        done_ff  <= 1'b0;
                        tmo_ff   <= 1'b0;
                        state_ff <= AIF_H_WAIT;
                    end
                end
                AIF_H_WAIT: begin
                    req_ff <= 1'b0;
                    if (bus.rd_ack) begin
                        raw_ff   <= bus.rd_data;
                        done_ff  <= 1'b1;
                        state_ff <= AIF_H_IDLE;
                    end else if (32'(cnt_ff) >= TMO_CYC - 1) begin
                        tmo_ff   <= 1'b1;
                        done_ff  <= 1'b1;
                        state_ff <= AIF_H_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
            endcase
        end
    end

    assign bus.rd_req        = req_ff;
    assign bus.rd_addr       = addr_ff;
    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out  = awready_ff;
    assign s_axi_bvalid_out  = bvalid_ff;
    assign s_axi_bresp_out   = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out  = rvalid_ff;
    assign s_axi_rresp_out   = rresp_ff;
    assign s_axi_rdata_out   = rdata_ff;
endmodule // aif_host
`default_nettype wire

// [logic/aif_pkg.sv]
`default_nettype none
package aif_pkg;
    // result memory geometry
    localparam int AIF_CHANNELS = 8;
    localparam int AIF_CH_W     = 3;
    localparam int AIF_WORD_W   = 16;
    localparam int AIF_RAW_W    = 14;
    localparam int AIF_ADDR_W   = 8;
    localparam logic [AIF_ADDR_W-1:0] AIF_WIN_BYTES = 8'h10;

    // result word layout
    localparam int AIF_OV_BIT     = 0;
    localparam int AIF_F_BIT      = 1;
    localparam int AIF_A_BIT      = 2;
    localparam int AIF_VAL_LSB    = 3;
    localparam int AIF_UNUSED_BIT = 14;
    localparam int AIF_HI_POL_BIT = 7;
    localparam int AIF_SIGN_BIT   = 8 + AIF_HI_POL_BIT;
    localparam logic [AIF_WORD_W-1:0] AIF_WORD_RST = 16'h0000;

    // unit limits and offsets, 16-bit signed
    localparam logic signed [15:0] AIF_UNI_MAX  = 16'sh0fff;
    localparam logic signed [15:0] AIF_UNI_MIN  = 16'sh0000;
    localparam logic signed [15:0] AIF_BI_MAX   = 16'sh07ff;
    localparam logic signed [15:0] AIF_BI_MIN   = -16'sh0800;
    localparam logic signed [15:0] AIF_SM_MIN   = -16'sh07ff;
    localparam logic signed [15:0] AIF_OVR_MAX  = 16'sh0fff;
    localparam logic signed [15:0] AIF_OVR_MIN  = -16'sh0fff;
    localparam logic signed [15:0] AIF_LZ_OFS   = 16'sh0200;
    localparam logic signed [15:0] AIF_LZ_MAX   = 16'sh0a00;
    localparam logic signed [15:0] AIF_BIN_OFS  = 16'sh0800;

    // result encodings selected by the static format switch
    typedef enum logic [1:0] {
        AIF_FMT_TWOS = 2'h0,
        AIF_FMT_SMAG = 2'h1,
        AIF_FMT_BIN  = 2'h2
    } aif_fmt_e;

    // module start address in the peripheral area
    localparam logic [AIF_ADDR_W-1:0] AIF_BASE_MIN = 8'h80;
    function automatic logic [AIF_ADDR_W-1:0] aif_base_addr(input logic [2:0] sel);
        return AIF_BASE_MIN + {1'b0, sel, 4'h0};
    endfunction

    // controller register map, byte offsets
    localparam logic [7:0] AIF_REG_CMD    = 8'h00;
    localparam logic [7:0] AIF_REG_CFG    = 8'h04;
    localparam logic [7:0] AIF_REG_LIMIT  = 8'h08;
    localparam logic [7:0] AIF_REG_STATUS = 8'h0c;
    localparam logic [7:0] AIF_REG_RAW    = 8'h10;
    localparam logic [7:0] AIF_REG_VALUE  = 8'h14;
    localparam logic [7:0]  AIF_CFG_RST   = 8'h00;
    localparam logic [15:0] AIF_LIMIT_RST = 16'h0000;
    localparam logic [1:0]  AIF_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  AIF_RESP_SLVERR = 2'h2;

    // read answer timeout
    localparam int AIF_CLK_PERIOD_NS = 50;
    localparam int AIF_RESP_TMO_NS   = 1000;
    localparam int AIF_RESP_TMO_CYC  =
        (AIF_RESP_TMO_NS + AIF_CLK_PERIOD_NS - 1) / AIF_CLK_PERIOD_NS;

    // controller sequencer
    typedef enum logic [1:0] {
        AIF_H_IDLE = 2'b01,
        AIF_H_WAIT = 2'b10
    } aif_hst_e;
endpackage
`default_nettype wire

// [test/aif_bus_monitor.sv]
`default_nettype none
module aif_bus_monitor (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic        rd_req,
    input wire logic [7:0]  rd_addr,
    input wire logic        rd_ack,
    input wire logic [15:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // read port handshake and result word hold
    chk_ack_has_req: assert property (rd_ack |-> $past(rd_req))
        else $error("ack without request");
    chk_req_answered: assert property (rd_req |=> rd_ack)
        else $error("request not answered next cycle");
    chk_ack_one_cycle: assert property (rd_ack |=> !rd_ack)
        else $error("ack longer than one cycle");
    chk_data_holds: assert property (!rd_ack |-> $stable(rd_data))
        else $error("result word moved without ack");
    chk_data_change_cause: assert property ($changed(rd_data) |-> rd_ack && $past(rd_req))
        else $error("result word changed without request");
    chk_req_gap: assert property (rd_req |=> !rd_req [*2])
        else $error("requests too close");
    chk_addr_window: assert property (rd_req |-> rd_addr[7] && !rd_addr[0])
        else $error("request outside peripheral window");
    chk_reset_quiet: assert property ($rose(reset_n_in) |-> !rd_ack && !rd_req)
        else $error("bus active right after reset");
    // main scenarios seen on the wire
    cover property (rd_ack && rd_data[0]);
    cover property (rd_ack && rd_data[1]);
    cover property (rd_ack && rd_data[2]);
endmodule // aif_bus_monitor
`default_nettype wire

// [test/testbench.sv]
`default_nettype none
module testbench;
    import aif_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] f; logic [4:0] m; logic [2:0] a; logic [2:0] c; logic [13:0] v; logic [15:0] e;
    } aif_row_s;
    // flags m: bipolar, simple, live zero, wire break, shunt
    aif_row_s rows [11] = '{
        '{2'h0, 5'h00, 3'h0, 3'h0, 14'h0fff, 16'h7ff8},
        '{2'h0, 5'h18, 3'h1, 3'h1, 14'h3800, 16'h8000},
        '{2'h0, 5'h18, 3'h2, 3'h2, 14'h3fff, 16'hbff8},
        '{2'h0, 5'h10, 3'h3, 3'h3, 14'h3001, 16'h8008},
        '{2'h1, 5'h10, 3'h4, 3'h4, 14'h3ffb, 16'h8028},
        '{2'h1, 5'h18, 3'h5, 3'h5, 14'h0bb8, 16'h3ff9},
        '{2'h2, 5'h10, 3'h6, 3'h6, 14'h3fff, 16'h3ff8},
        '{2'h0, 5'h04, 3'h7, 3'h7, 14'h0000, 16'h1000},
        '{2'h0, 5'h0c, 3'h0, 3'h1, 14'h0834, 16'h5001},
        '{2'h0, 5'h02, 3'h1, 3'h0, 14'h0064, 16'h0322},
        '{2'h0, 5'h03, 3'h2, 3'h0, 14'h0064, 16'h0320}
    };
    logic clk_in, reset_n_in, conv_done, wb_in, scan_start, simp, bip, lz, shunt, xdcr, supply;
    logic [2:0] chan, scan_chan, base;
    logic [1:0] fmt, bresp, rresp, resp;
    logic [13:0] val;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata_w, rd;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    int mismatches = 0;
    int total_checks = 0;
    aif_bus_if bus ();
    aif_device aif_device_inst (.clk_in, .reset_n_in, .ce_in(1'b1), .bus(bus.dev),
        .conv_done_in(conv_done), .conv_chan_in(chan), .conv_value_in(val),
        .conv_wire_break_in(wb_in), .scan_start_in(scan_start), .scan_chan_in(scan_chan),
        .fmt_sel_in(fmt), .base_sel_in(base), .simple_variant_in(simp), .bipolar_range_in(bip),
        .live_zero_in(lz), .shunt_adapter_in(shunt), .xdcr_break_in(xdcr),
        .supply_break_in(supply));
    aif_host aif_host_inst (.clk_in, .reset_n_in, .ce_in(1'b1), .bus(bus.host),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata_w), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
    aif_bus_monitor mon (.clk_in, .reset_n_in, .rd_req(bus.rd_req), .rd_addr(bus.rd_addr),
        .rd_ack(bus.rd_ack), .rd_data(bus.rd_data));
    // bus master cycles: each valid dropped at the edge its ready is seen
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(posedge clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge clk_in);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata_w;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_word(input logic [2:0] c, output logic [31:0] w);
        axi_wr(AIF_REG_CMD, {29'h0, c});
        do axi_rd(AIF_REG_STATUS, w); while (w[1:0] !== 2'h2);
        axi_rd(AIF_REG_RAW, w);
    endtask
    // static pins and the matching controller setting
    task automatic setup(input logic [1:0] f, input logic [4:0] m, input logic [2:0] a);
        {fmt, bip, simp, lz, shunt, base} <= {f, m[4:2], m[0], a};
        axi_wr(AIF_REG_CFG, {24'h0, m[3], m[2], m[4], f, a});
        repeat (3) @(posedge clk_in);
    endtask
    task automatic conv(input logic [2:0] c, input logic [13:0] v, input logic w);
        @(posedge clk_in);
        {conv_done, chan, val, wb_in} <= {1'b1, c, v, w};
        @(posedge clk_in);
        conv_done <= 1'b0;
    endtask
    task automatic strobe(input logic [2:0] s, input logic [2:0] c);
        @(posedge clk_in);
        {supply, xdcr, scan_start, scan_chan} <= {s, c};
        @(posedge clk_in);
        {supply, xdcr, scan_start} <= 3'h0;
    endtask
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic end_sim();
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        repeat (30000) @(posedge clk_in);
        mismatches++;
        end_sim();
    end
    // main sequence: reset, table rows, then flag cases
    initial begin
        {conv_done, wb_in, scan_start, simp, bip, lz, shunt, xdcr, supply} = '0;
        {awvalid, wvalid, bready, arvalid, rready, chan, scan_chan, base, fmt, val} = '0;
        {awaddr, araddr, wdata} = '0;
        reset_n_in = 1'b0;
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        axi_rd(AIF_REG_CFG, rd);
        check("cfg reset", 16'h0, rd[15:0]);
        rd_word(3'h3, rd);
        check("word reset", 16'h0, rd[15:0]);
        axi_rd(8'h20, rd);
        check("unmapped resp", {14'h0, AIF_RESP_SLVERR}, {14'h0, resp});
        axi_wr(8'h20, 32'h0);
        check("unmapped write resp", {14'h0, AIF_RESP_SLVERR}, {14'h0, resp});
        foreach (rows[i]) begin
            setup(rows[i].f, rows[i].m, rows[i].a);
            conv(rows[i].c, rows[i].v, rows[i].m[1]);
            rd_word(rows[i].c, rd);
            check("row word", rows[i].e, rd[15:0]);
        end
        setup(2'h0, 5'h00, 3'h0);
        strobe(3'h1, 3'h5);
        rd_word(3'h5, rd);
        check("activity set", 16'h3ffd, rd[15:0]);
        conv(3'h5, 14'h0, 1'b0);
        rd_word(3'h5, rd);
        check("activity cleared", 16'h0000, rd[15:0]);
        strobe(3'h4, 3'h0);
        rd_word(3'h0, rd);
        check("supply break", 16'h0323, rd[15:0]);
        rd_word(3'h3, rd);
        check("supply break other", 16'h800b, rd[15:0]);
        conv(3'h7, 14'h0, 1'b0);
        strobe(3'h2, 3'h0);
        rd_word(3'h7, rd);
        check("transducer break", 16'h0001, rd[15:0]);
        setup(2'h0, 5'h08, 3'h0);
        strobe(3'h1, 3'h4);
        rd_word(3'h4, rd);
        check("simple activity", 16'h802b, rd[15:0]);
        setup(2'h0, 5'h04, 3'h0);
        conv(3'h7, 14'h0064, 1'b0);
        rd_word(3'h7, rd);
        axi_rd(AIF_REG_VALUE, rd);
        check("live zero value", 16'h0064, rd[15:0]);
        axi_wr(AIF_REG_LIMIT, 32'h0000_00c8);
        axi_rd(AIF_REG_STATUS, rd);
        check("below limit", 16'h0042, rd[15:0]);
        reset_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd_word(3'h7, rd);
        check("word after reset", 16'h0000, rd[15:0]);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
